// ---- src/hptt_pkg.sv ----
// hptt_pkg: constants and carrier types for the host-port tail tag and
// rapid spanning tree gating block.
// assumes a 32-bit APB register bus and a byte-wide MII-family uplink stream.
package hptt_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_GLOBAL = 8'h00;
	localparam logic [7:0] OFF_PORT1 = 8'h04;
	localparam logic [7:0] OFF_PORT2 = 8'h08;
	localparam logic [7:0] OFF_PORT3 = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;

	// field positions
	localparam int GLB_TAIL_EN_BIT = 1;
	localparam int PC_TX_EN_BIT = 0;
	localparam int PC_RX_EN_BIT = 1;
	localparam int PC_LEARN_DIS_BIT = 2;
	localparam int PC_FLUSH_STA_BIT = 4;
	localparam int PC_FLUSH_DYN_BIT = 5;
	localparam int ST_FIELD_W = 3;

	// reset values: tail tag off, every port discarding
	localparam logic RST_TAIL_EN = 1'b0;
	localparam logic RST_TX_EN = 1'b0;
	localparam logic RST_RX_EN = 1'b0;
	localparam logic RST_LEARN_DIS = 1'b1;

	// frame check sequence
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam int FCS_BYTES = 4;
	localparam int IG_DEPTH = FCS_BYTES + 1;
	localparam int EG_DEPTH = FCS_BYTES;

	// tail byte codes, host to switch
	localparam logic [3:0] TT_DST_P1 = 4'h1;
	localparam logic [3:0] TT_DST_P2 = 4'h2;
	localparam logic [3:0] TT_DST_P3 = 4'h4;
	localparam logic [3:0] TT_DST_ALL = 4'hF;

	// tail byte codes, switch to host
	localparam logic [1:0] TT_SRC_P1 = 2'h0;
	localparam logic [1:0] TT_SRC_P2 = 2'h1;
	localparam logic [1:0] TT_SRC_P3 = 2'h2;
	localparam logic [1:0] TT_SRC_RSVD = 2'h3;

	typedef enum logic [2:0] {
		ST_DISCARD = 3'b001,
		ST_LEARN = 3'b010,
		ST_FORWARD = 3'b100
	} hptt_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} hptt_beat_t;

	typedef struct packed {
		logic tx_en;
		logic rx_en;
		logic learn_dis;
	} hptt_port_ctl_t;

	typedef struct packed {
		logic [2:0] dest;
		logic [1:0] queue;
		logic force_dst;
		logic lookup;
		logic rsvd;
	} hptt_ig_meta_t;

endpackage

// ---- src/hptt_top.sv ----
// hptt_top: spanning tree port gating and tail tag strip/insert on the
// uplink_gigabit_media_if host port, with an APB register slave.
// assumes byte streams that carry their frame check sequence and are at
// least six bytes long; the switch side stream toward the host obeys ready.
// Functional notes
// (RULE1) each port in one of three states
// (RULE2) discarding: no topology role, no learning
// (RULE3) learning: learn addresses, forward no user traffic
// (RULE4) forwarding: forward and learn
// (RULE5) tx0 rx0 learndis1 selects discarding, learning off
// (RULE6) override matches still reach host when discarding
// (RULE7) host sends nothing to discarding ports
// (RULE8) both flush bits with learning off flush tables
// (RULE9) tx0 rx0 learndis0 selects learning, host-only traffic
// (RULE10) tx1 rx1 learndis0 selects forwarding
// (RULE11) host programs override static entries
// (RULE12) host may address ports by tail tag
// (RULE13) one tail byte, host uplink only
// (RULE14) tail handling only while enable bit set
// (RULE15) low nibble alone picks destination
// (RULE16) low nibble destination decode
// (RULE17) upper nibble 00xx picks egress queue
// (RULE18) upper nibble 01xx forces delivery
// (RULE19) top bit set: normal address lookup
// (RULE20) ingress port encoded in bits one and zero
// (RULE21) tail byte before FCS, FCS recomputed
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps

module hptt_top (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic hrx_valid_i,
	input wire hptt_pkg::hptt_beat_t hrx_beat_i,
	output logic swi_valid_o,
	output hptt_pkg::hptt_beat_t swi_beat_o,
	output logic ig_meta_valid_o,
	output hptt_pkg::hptt_ig_meta_t ig_meta_o,
	input wire logic swe_valid_i,
	input wire hptt_pkg::hptt_beat_t swe_beat_i,
	input wire logic [2:0] swe_src_i,
	output logic swe_ready_o,
	output logic htx_valid_o,
	output hptt_pkg::hptt_beat_t htx_beat_o,
	output logic [2:0] learn_en_o,
	output logic [2:0] fwd_en_o,
	output logic [2:0] host_only_o,
	output logic [2:0] flush_o
);

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ hptt_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	logic tail_en_q;
	hptt_pkg::hptt_port_ctl_t ctl_q [3];
	hptt_pkg::hptt_state_t state_q [3];
	logic wr_acc;
	logic [31:0] status_w;

	// apb: setup cycle latches the answer, access cycle completes
	assign wr_acc = psel_i & penable_i & pready_o & pwrite_i;

	always_comb
	begin
		status_w = 32'h00000000;
		for (int p = 0; p < 3; p++)
		begin
			status_w[p*hptt_pkg::ST_FIELD_W +: hptt_pkg::ST_FIELD_W] = state_q[p];
		end
	end

	// read data, ready and error answer
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= psel_i & ~penable_i;
			prdata_o <= 32'h00000000;
			pslverr_o <= 1'b0;
			if (psel_i & ~penable_i)
			begin
				unique case (paddr_i)
					hptt_pkg::OFF_GLOBAL:
						prdata_o[hptt_pkg::GLB_TAIL_EN_BIT] <= tail_en_q;
					hptt_pkg::OFF_PORT1, hptt_pkg::OFF_PORT2, hptt_pkg::OFF_PORT3:
					begin
						prdata_o[hptt_pkg::PC_TX_EN_BIT] <= ctl_q[paddr_i[3:2]-2'd1].tx_en;
						prdata_o[hptt_pkg::PC_RX_EN_BIT] <= ctl_q[paddr_i[3:2]-2'd1].rx_en;
						prdata_o[hptt_pkg::PC_LEARN_DIS_BIT] <=
							ctl_q[paddr_i[3:2]-2'd1].learn_dis;
					end
					hptt_pkg::OFF_STATUS:
						prdata_o <= status_w;
					default:
						pslverr_o <= 1'b1;
				endcase
			end
		end
	end

	// global control
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			tail_en_q <= hptt_pkg::RST_TAIL_EN;
		else if (wr_acc && paddr_i == hptt_pkg::OFF_GLOBAL)
			tail_en_q <= pwdata_i[hptt_pkg::GLB_TAIL_EN_BIT];
	end

	// per-port control, state decode and flush request
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			for (int p = 0; p < 3; p++)
			begin
				ctl_q[p] <= '{hptt_pkg::RST_TX_EN, hptt_pkg::RST_RX_EN,
					hptt_pkg::RST_LEARN_DIS};
				state_q[p] <= hptt_pkg::ST_DISCARD;
			end
			flush_o <= 3'b000;
		end
		else
		begin
			for (int p = 0; p < 3; p++)
			begin
				flush_o[p] <= 1'b0;
				if (wr_acc && paddr_i == 8'((p + 1) * 4))
				begin
					ctl_q[p].tx_en <= pwdata_i[hptt_pkg::PC_TX_EN_BIT];
					ctl_q[p].rx_en <= pwdata_i[hptt_pkg::PC_RX_EN_BIT];
					ctl_q[p].learn_dis <= pwdata_i[hptt_pkg::PC_LEARN_DIS_BIT];
					flush_o[p] <= pwdata_i[hptt_pkg::PC_FLUSH_DYN_BIT] &
						pwdata_i[hptt_pkg::PC_FLUSH_STA_BIT] &
						pwdata_i[hptt_pkg::PC_LEARN_DIS_BIT]; // RULE8
				end
				if (ctl_q[p].learn_dis)
					state_q[p] <= hptt_pkg::ST_DISCARD; // RULE1 RULE5
				else if (ctl_q[p].tx_en & ctl_q[p].rx_en)
					state_q[p] <= hptt_pkg::ST_FORWARD; // RULE10
				else
					state_q[p] <= hptt_pkg::ST_LEARN; // RULE9
			end
		end
	end

	// gating outputs; host-bound override frames are never gated here
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			learn_en_o <= 3'b000;
			fwd_en_o <= 3'b000;
			host_only_o <= 3'b000;
		end
		else
		begin
			for (int p = 0; p < 3; p++)
			begin
				unique case (state_q[p])
					hptt_pkg::ST_DISCARD:
					begin
						learn_en_o[p] <= 1'b0; // RULE2 RULE6
						fwd_en_o[p] <= 1'b0;
						host_only_o[p] <= 1'b0;
					end
					hptt_pkg::ST_LEARN:
					begin
						learn_en_o[p] <= 1'b1; // RULE3
						fwd_en_o[p] <= 1'b0;
						host_only_o[p] <= 1'b1;
					end
					hptt_pkg::ST_FORWARD:
					begin
						learn_en_o[p] <= 1'b1; // RULE4
						fwd_en_o[p] <= 1'b1;
						host_only_o[p] <= 1'b0;
					end
				endcase
			end
		end
	end

	// host to switch: hold five bytes so the tail byte and FCS can be cut
	logic [7:0] ig_p_q [hptt_pkg::IG_DEPTH];
	logic [2:0] ig_cnt_q;
	logic [31:0] ig_crc_q;
	logic [7:0] ig_tr_q [hptt_pkg::IG_DEPTH];
	logic [2:0] ig_tr_n_q;
	logic ig_emit;
	logic [31:0] ig_crc_d;
	logic [7:0] tag;
	logic [2:0] dst;
	logic [2:0] live;

	assign ig_emit = hrx_valid_i && ig_cnt_q == 3'(hptt_pkg::IG_DEPTH);
	assign ig_crc_d = crc_byte(ig_crc_q, ig_p_q[4]);
	assign tag = ig_p_q[3];

	always_comb
	begin
		for (int p = 0; p < 3; p++)
		begin
			live[p] = (state_q[p] != hptt_pkg::ST_DISCARD); // RULE7
		end
		unique case (tag[3:0]) // RULE15 RULE16
			hptt_pkg::TT_DST_P1: dst = 3'b001;
			hptt_pkg::TT_DST_P2: dst = 3'b010;
			hptt_pkg::TT_DST_P3: dst = 3'b100;
			hptt_pkg::TT_DST_ALL: dst = 3'b111;
			default: dst = 3'b000;
		endcase
	end

	// input delay line
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ig_cnt_q <= 3'd0;
			for (int i = 0; i < hptt_pkg::IG_DEPTH; i++)
				ig_p_q[i] <= 8'h00;
		end
		else if (hrx_valid_i)
		begin
			ig_p_q[0] <= hrx_beat_i.data;
			for (int i = 1; i < hptt_pkg::IG_DEPTH; i++)
				ig_p_q[i] <= ig_p_q[i-1];
			if (hrx_beat_i.last)
				ig_cnt_q <= 3'd0;
			else if (!ig_emit)
				ig_cnt_q <= ig_cnt_q + 3'd1;
		end
	end

	// output toward switch, FCS regenerated after stripping
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			swi_valid_o <= 1'b0;
			swi_beat_o <= '0;
			ig_crc_q <= hptt_pkg::CRC_INIT;
			ig_tr_n_q <= 3'd0;
			for (int i = 0; i < hptt_pkg::IG_DEPTH; i++)
				ig_tr_q[i] <= 8'h00;
		end
		else
		begin
			swi_valid_o <= 1'b0;
			if (ig_emit)
			begin
				swi_valid_o <= 1'b1;
				swi_beat_o <= '{ig_p_q[4], 1'b0};
				ig_crc_q <= ig_crc_d;
				if (hrx_beat_i.last)
				begin
					ig_crc_q <= hptt_pkg::CRC_INIT;
					if (tail_en_q) // RULE14 RULE21
					begin
						for (int i = 0; i < hptt_pkg::FCS_BYTES; i++)
							ig_tr_q[i] <= ~ig_crc_d[i*8 +: 8];
						ig_tr_n_q <= 3'(hptt_pkg::FCS_BYTES);
					end
					else
					begin
						ig_tr_q <= '{ig_p_q[3], ig_p_q[2], ig_p_q[1], ig_p_q[0],
							hrx_beat_i.data};
						ig_tr_n_q <= 3'(hptt_pkg::IG_DEPTH);
					end
				end
			end
			else if (ig_tr_n_q != 3'd0)
			begin
				swi_valid_o <= 1'b1;
				swi_beat_o <= '{ig_tr_q[0], ig_tr_n_q == 3'd1};
				for (int i = 0; i < hptt_pkg::IG_DEPTH - 1; i++)
					ig_tr_q[i] <= ig_tr_q[i+1];
				ig_tr_n_q <= ig_tr_n_q - 3'd1;
			end
		end
	end

	// forwarding override decoded from the stripped tail byte
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ig_meta_valid_o <= 1'b0;
			ig_meta_o <= '0;
		end
		else
		begin
			ig_meta_valid_o <= ig_emit & hrx_beat_i.last;
			if (ig_emit & hrx_beat_i.last)
			begin
				ig_meta_o <= '0;
				if (!tail_en_q || tag[7])
					ig_meta_o.lookup <= 1'b1; // RULE19 RULE13
				else
				begin
					ig_meta_o.dest <= dst & live; // RULE12
					ig_meta_o.rsvd <= (dst == 3'b000);
					ig_meta_o.force_dst <= tag[6]; // RULE18
					ig_meta_o.queue <= tag[6] ? 2'd0 : tag[5:4]; // RULE17
				end
			end
		end
	end

	// switch to host: hold four bytes, replace FCS with tail byte and new FCS
	logic [7:0] eg_p_q [hptt_pkg::EG_DEPTH];
	logic [2:0] eg_cnt_q;
	logic [31:0] eg_crc_q;
	logic [7:0] eg_tr_q [hptt_pkg::IG_DEPTH];
	logic [2:0] eg_tr_n_q;
	logic eg_acc;
	logic eg_emit;
	logic [31:0] eg_crc_a;
	logic [31:0] eg_crc_b;
	logic [7:0] eg_tag;

	assign eg_acc = swe_valid_i & swe_ready_o;
	assign eg_emit = eg_acc && eg_cnt_q == 3'(hptt_pkg::EG_DEPTH);
	assign eg_crc_a = crc_byte(eg_crc_q, eg_p_q[3]);
	assign eg_crc_b = crc_byte(eg_crc_a, eg_tag);

	always_comb
	begin
		unique case (swe_src_i) // RULE20
			3'b001: eg_tag = {6'h00, hptt_pkg::TT_SRC_P1};
			3'b010: eg_tag = {6'h00, hptt_pkg::TT_SRC_P2};
			3'b100: eg_tag = {6'h00, hptt_pkg::TT_SRC_P3};
			default: eg_tag = {6'h00, hptt_pkg::TT_SRC_RSVD};
		endcase
	end

	// egress delay line and back-pressure while the trailer drains
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			eg_cnt_q <= 3'd0;
			swe_ready_o <= 1'b1;
			for (int i = 0; i < hptt_pkg::EG_DEPTH; i++)
				eg_p_q[i] <= 8'h00;
		end
		else
		begin
			if (eg_acc)
			begin
				eg_p_q[0] <= swe_beat_i.data;
				for (int i = 1; i < hptt_pkg::EG_DEPTH; i++)
					eg_p_q[i] <= eg_p_q[i-1];
				if (swe_beat_i.last)
					eg_cnt_q <= 3'd0;
				else if (!eg_emit)
					eg_cnt_q <= eg_cnt_q + 3'd1;
			end
			if (eg_emit & swe_beat_i.last)
				swe_ready_o <= 1'b0;
			else if (eg_tr_n_q == 3'd1)
				swe_ready_o <= 1'b1;
		end
	end

	// output toward host
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			htx_valid_o <= 1'b0;
			htx_beat_o <= '0;
			eg_crc_q <= hptt_pkg::CRC_INIT;
			eg_tr_n_q <= 3'd0;
			for (int i = 0; i < hptt_pkg::IG_DEPTH; i++)
				eg_tr_q[i] <= 8'h00;
		end
		else
		begin
			htx_valid_o <= 1'b0;
			if (eg_emit)
			begin
				htx_valid_o <= 1'b1;
				htx_beat_o <= '{eg_p_q[3], 1'b0};
				eg_crc_q <= eg_crc_a;
				if (swe_beat_i.last)
				begin
					eg_crc_q <= hptt_pkg::CRC_INIT;
					if (tail_en_q) // RULE14 RULE21 RULE13
					begin
						eg_tr_q <= '{eg_tag, ~eg_crc_b[7:0], ~eg_crc_b[15:8],
							~eg_crc_b[23:16], ~eg_crc_b[31:24]};
						eg_tr_n_q <= 3'(hptt_pkg::IG_DEPTH);
					end
					else
					begin
						eg_tr_q <= '{eg_p_q[2], eg_p_q[1], eg_p_q[0],
							swe_beat_i.data, 8'h00};
						eg_tr_n_q <= 3'(hptt_pkg::FCS_BYTES);
					end
				end
			end
			else if (eg_tr_n_q != 3'd0)
			begin
				htx_valid_o <= 1'b1;
				htx_beat_o <= '{eg_tr_q[0], eg_tr_n_q == 3'd1};
				for (int i = 0; i < hptt_pkg::IG_DEPTH - 1; i++)
					eg_tr_q[i] <= eg_tr_q[i+1];
				eg_tr_n_q <= eg_tr_n_q - 3'd1;
			end
		end
	end

endmodule

// ---- tb/hptt_sva.sv ----
// hptt_sva: port-level checks on hptt_top, bound below.
// assumes one clock domain, reset active low.
`timescale 1ns/1ps
module hptt_sva (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic ig_meta_valid_o,
	input wire logic swe_valid_i,
	input wire hptt_pkg::hptt_beat_t swe_beat_i,
	input wire logic swe_ready_o,
	input wire logic htx_valid_o,
	input wire hptt_pkg::hptt_beat_t htx_beat_o,
	input wire logic [2:0] learn_en_o,
	input wire logic [2:0] fwd_en_o,
	input wire logic [2:0] host_only_o,
	input wire logic [2:0] flush_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	// register bus answer
	chk_apb_answer: assert property (psel_i && !penable_i |=> pready_o && penable_i)
		else $error("no answer after setup");
	chk_err_unmapped: assert property (psel_i && !penable_i && paddr_i > 8'h10 |=> pslverr_o)
		else $error("unmapped access not refused");
	chk_err_zero: assert property (pslverr_o |-> prdata_o == 32'h0)
		else $error("refused read not zero");
	// port gating shows one state; flush and meta outputs pulse for one cycle
	chk_one_state: assert property (
		(host_only_o ^ fwd_en_o) == learn_en_o && (host_only_o & fwd_en_o) == 3'h0)
		else $error("port gating not one state");
	chk_flush_pulse: assert property (flush_o != 3'h0 |=> flush_o == 3'h0)
		else $error("flush pulse too long");
	chk_meta_pulse: assert property (ig_meta_valid_o |=> !ig_meta_valid_o)
		else $error("meta pulse too long");
	// egress trailer holds off the switch side
	chk_ready_drop: assert property (
		swe_valid_i && swe_ready_o && swe_beat_i.last |=> !swe_ready_o)
		else $error("ready kept after last");
	chk_ready_back: assert property (
		$fell(swe_ready_o) |-> !swe_ready_o [*3] ##[1:12] swe_ready_o)
		else $error("trailer hold wrong");
	chk_ready_after: assert property (htx_valid_o && htx_beat_o.last |=> swe_ready_o)
		else $error("ready not back after trailer");
endmodule
bind hptt_top hptt_sva i_hptt_sva (.mclk_i, .nrst_i, .psel_i, .penable_i, .paddr_i, .prdata_o,
	.pready_o, .pslverr_o, .ig_meta_valid_o, .swe_valid_i, .swe_beat_i, .swe_ready_o,
	.htx_valid_o, .htx_beat_o, .learn_en_o, .fwd_en_o, .host_only_o, .flush_o);

// ---- tb/hptt_host_mac.sv ----
// hptt_host_mac: host side mac, sends tagged frames, collects host bound bytes.
// assumes the bench calls send just after a rising edge.
`timescale 1ns/1ps
module hptt_host_mac (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic tx_valid_i,
	input wire hptt_pkg::hptt_beat_t tx_beat_i,
	output logic rx_valid_o,
	output hptt_pkg::hptt_beat_t rx_beat_o
);
	logic [7:0] rxq[$];
	initial
	begin
		rx_valid_o = 1'h0;
		rx_beat_o = '0;
	end
	// collect frames toward host
	always @(posedge mclk_i)
		if (tx_valid_i === 1'h1)
			rxq.push_back(tx_beat_i.data);
	// one frame, tail byte before fcs; overrides assumed programmed by host
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i])
		begin
			rx_valid_o <= 1'h1;
			rx_beat_o <= {b[i], i == b.size() - 1};
			@(posedge mclk_i);
		end
		rx_valid_o <= 1'h0;
		rx_beat_o <= ~rx_beat_o; // idle line toggles
	endtask
endmodule

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for hptt_top.
// assumes hptt_host_mac on the host side and the bound checker.
`timescale 1ns/1ps
module tb_top;
	logic mclk_i = 1'h0;
	logic nrst_i = 1'h0;
	logic psel_i = 1'h0;
	logic penable_i = 1'h0;
	logic pwrite_i = 1'h0;
	logic [7:0] paddr_i = 8'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic hrx_valid_i;
	hptt_pkg::hptt_beat_t hrx_beat_i;
	logic swi_valid_o;
	hptt_pkg::hptt_beat_t swi_beat_o;
	logic ig_meta_valid_o;
	hptt_pkg::hptt_ig_meta_t ig_meta_o;
	logic swe_valid_i = 1'h0;
	hptt_pkg::hptt_beat_t swe_beat_i = '0;
	logic [2:0] swe_src_i = 3'h1;
	logic swe_ready_o;
	logic htx_valid_o;
	hptt_pkg::hptt_beat_t htx_beat_o;
	logic [2:0] learn_en_o;
	logic [2:0] fwd_en_o;
	logic [2:0] host_only_o;
	logic [2:0] flush_o;
	logic [31:0] rdat;
	logic rerr;
	logic [7:0] meta_q;
	logic [2:0] fl_q = 3'h0;
	logic [7:0] swiq[$];
	int err_count = 0;
	int checks_done = 0;
	always #12.5 mclk_i = ~mclk_i;
	hptt_top i_hptt_top (.mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .hrx_valid_i, .hrx_beat_i, .swi_valid_o, .swi_beat_o,
		.ig_meta_valid_o, .ig_meta_o, .swe_valid_i, .swe_beat_i, .swe_src_i, .swe_ready_o,
		.htx_valid_o, .htx_beat_o, .learn_en_o, .fwd_en_o, .host_only_o, .flush_o);
	hptt_host_mac i_hptt_host_mac (.mclk_i, .nrst_i, .tx_valid_i(htx_valid_o),
		.tx_beat_i(htx_beat_o), .rx_valid_o(hrx_valid_i), .rx_beat_o(hrx_beat_i));
	// collect switch bound bytes, last meta, flush pulses
	always @(posedge mclk_i)
	begin
		if (swi_valid_o === 1'h1)
			swiq.push_back(swi_beat_o.data);
		if (ig_meta_valid_o === 1'h1)
			meta_q <= ig_meta_o;
		fl_q <= fl_q | flush_o;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x)
		begin
			err_count++;
			$display("Error %s exp %h seen %h", nm, x, s);
		end
	endtask
	// apb transfer, one idle cycle after
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'h1;
		do @(posedge mclk_i); while (pready_o !== 1'h1);
		rdat = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge mclk_i);
	endtask
	function automatic void add_fcs(ref logic [7:0] q[$]);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		foreach (q[i])
		begin
			c = c ^ {24'h0, q[i]};
			repeat (8)
				c = c[0] ? (c >> 1) ^ hptt_pkg::CRC_POLY : c >> 1;
		end
		for (int k = 0; k < 4; k++)
			q.push_back(~c[8 * k +: 8]);
	endfunction
	task automatic sw_send(input logic [7:0] b[$]);
		foreach (b[i])
		begin
			swe_valid_i <= 1'h1;
			swe_beat_i <= {b[i], i == b.size() - 1};
			do @(posedge mclk_i); while (swe_ready_o !== 1'h1);
		end
		swe_valid_i <= 1'h0;
		swe_beat_i <= ~swe_beat_i;
	endtask
	task automatic cmpq(input logic [7:0] s[$], input logic [7:0] x[$]);
		chk("len", s.size(), x.size());
		foreach (x[i])
			chk("byte", s[i], x[i]);
	endtask
	// one frame either way; t is tail byte or expected tag
	task automatic xfer(input logic ig, input logic on, input logic [7:0] t,
		input logic [2:0] s, input logic [7:0] mx, input logic [7:0] mm);
		logic [7:0] d[$];
		logic [7:0] w[$];
		logic [7:0] r[$];
		for (int k = 0; k < 6; k++)
			d.push_back(8'hA0 + 8'(k) + t);
		w = d;
		add_fcs(w);
		d.push_back(t);
		add_fcs(d);
		swiq.delete();
		i_hptt_host_mac.rxq.delete();
		meta_q = 8'h55;
		swe_src_i <= s;
		if (ig)
			i_hptt_host_mac.send(d);
		else
			sw_send(w);
		for (int n = 0; n < 40 && (ig ? swiq.size() : i_hptt_host_mac.rxq.size()) < 11; n++)
			@(posedge mclk_i);
		repeat (4) @(posedge mclk_i);
		if (ig)
			r = swiq;
		else
			r = i_hptt_host_mac.rxq;
		cmpq(r, (ig ^ on) ? d : w);
		if (ig)
			chk("meta", meta_q & mm, mx);
	endtask
	task automatic t_reset();
		apb(1'h0, hptt_pkg::OFF_STATUS, 32'h0);
		chk("status", rdat, 32'h49);
		chk("gates", {learn_en_o, fwd_en_o, host_only_o}, 32'h0);
		apb(1'h0, hptt_pkg::OFF_PORT1, 32'h0);
		chk("port1", rdat, 32'h4);
		apb(1'h1, 8'h14, 32'hFFFF);
		chk("slverr", rerr, 1'h1);
	endtask
	task automatic t_states();
		apb(1'h1, hptt_pkg::OFF_PORT1, 32'h0);
		apb(1'h1, hptt_pkg::OFF_PORT2, 32'h3);
		apb(1'h1, hptt_pkg::OFF_PORT3, 32'h4);
		repeat (2) @(posedge mclk_i);
		apb(1'h0, hptt_pkg::OFF_STATUS, 32'h0);
		chk("status", rdat, 32'h62);
		chk("learn", learn_en_o, 3'h3);
		chk("fwd", fwd_en_o, 3'h2);
		chk("host_only", host_only_o, 3'h1);
	endtask
	task automatic t_flush();
		apb(1'h1, hptt_pkg::OFF_PORT1, 32'h30);
		apb(1'h1, hptt_pkg::OFF_PORT3, 32'h34);
		repeat (3) @(posedge mclk_i);
		chk("flush", fl_q, 3'h4);
	endtask
	task automatic t_ingress();
		logic [7:0] tg[9] = '{8'h01, 8'h02, 8'h04, 8'h0F, 8'h31, 8'h41, 8'h80, 8'h08, 8'h00};
		logic [7:0] mx[9] = '{8'h20, 8'h40, 8'h00, 8'h60, 8'h38, 8'h24, 8'h02, 8'h01, 8'h01};
		logic [7:0] mm[9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'hFF, 8'hFF};
		apb(1'h1, hptt_pkg::OFF_PORT1, 32'h3);
		apb(1'h1, hptt_pkg::OFF_PORT2, 32'h3);
		apb(1'h1, hptt_pkg::OFF_GLOBAL, 32'h2);
		repeat (2) @(posedge mclk_i);
		foreach (tg[i])
			xfer(1'h1, 1'h1, tg[i], 3'h1, mx[i], mm[i]);
	endtask
	task automatic t_egress();
		logic [2:0] sr[4] = '{3'h1, 3'h2, 3'h4, 3'h3};
		foreach (sr[i])
			xfer(1'h0, 1'h1, 8'(i), sr[i], 8'h0, 8'h0);
	endtask
	task automatic t_tail_off();
		apb(1'h1, hptt_pkg::OFF_GLOBAL, 32'h0);
		repeat (2) @(posedge mclk_i);
		xfer(1'h1, 1'h0, 8'h01, 3'h1, 8'h02, 8'h02);
		xfer(1'h0, 1'h0, 8'h00, 3'h2, 8'h0, 8'h0);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// watchdog against a hang
	initial
	begin
		repeat (6000) @(posedge mclk_i);
		err_count++;
		end_sim();
	end
	// reset, then the scenarios
	initial
	begin
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1'h1;
		@(posedge mclk_i);
		t_reset();
		t_states();
		t_flush();
		t_ingress();
		t_egress();
		t_tail_off();
		end_sim();
	end
endmodule
